// file: hw/spm_params.svh
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port
`define SPM_OFF_CTRL 6'h00
`define SPM_OFF_BLOCK 6'h04
`define SPM_OFF_ROW 6'h08
`define SPM_OFF_COL 6'h0c
`define SPM_OFF_DATA 6'h10
`define SPM_OFF_STAT 6'h14

// Field positions
`define SPM_CTRL_X24_BIT 0
`define SPM_CTRL_INV_BIT 1
`define SPM_ROW_CLR_BIT 7
`define SPM_STAT_BUSY_BIT 0

// Reset values
`define SPM_RST_ROW 5'h00
`define SPM_RST_COL 6'h00
`define SPM_RST_BLOCK 4'h0
`define SPM_RST_CTRL 2'h0

// Processor address map
`define SPM_AUX_HI 16'h1fff
`define SPM_TXT_LO 16'h2000
`define SPM_TXT_HI 16'h47ff
`define SPM_CC_LO 16'h8000
`define SPM_CC_HI 16'h86ff

// Physical DRAM layout
`define SPM_DISP_BASE 15'h2000
`define SPM_MEM_WORDS 15'h4800
`define SPM_DISP_LAST 14'h27ff
`define SPM_BLOCK_LAST 14'h03ff

// Page geometry and fill codes
`define SPM_SPACE 8'h20
`define SPM_INV_FILL 8'h00
`define SPM_INV_BLOCK 4'h8
`define SPM_COL_MAX 6'h27
`define SPM_COL_SPLIT 6'h20
`define SPM_ROW_LAST 5'h19
`define SPM_COL_LAST 6'h17
`define SPM_HIGH_TOP 10'h3f8
`define SPM_ROW24 5'h18
`define SPM_CAP_P27_IDX 5'h17
`define SPM_CAP_LAST_IDX 5'h18
`define SPM_UNMAPPED_DATA 8'hff

// AXI responses
`define SPM_RESP_OKAY 2'b00
`define SPM_RESP_SLVERR 2'b10

// Timing
`define SPM_CLK_NS 10
`define SPM_REFRESH_NS 15600
`define SPM_REFRESH_CYC ((`SPM_REFRESH_NS) / (`SPM_CLK_NS))

`endif

// file: hw/spm_pkg.sv
package spm_pkg;

  typedef enum logic [1:0] {
    SPM_CLR_IDLE = 2'b01,
    SPM_CLR_RUN = 2'b10
  } spm_clr_state_t;

  typedef enum logic [2:0] {
    SPM_JOB_RST = 3'b001,
    SPM_JOB_SW = 3'b010,
    SPM_JOB_CAP = 3'b100
  } spm_job_t;

  typedef enum logic [4:0] {
    SPM_GNT_NONE = 5'b00001,
    SPM_GNT_DISP = 5'b00010,
    SPM_GNT_CLR = 5'b00100,
    SPM_GNT_CPU = 5'b01000,
    SPM_GNT_REG = 5'b10000
  } spm_gnt_t;

  // External data move request from the processor core
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } spm_cpu_req_t;

  // Capture-forced page clear order
  typedef struct packed {
    logic clear;
    logic [3:0] block;
    logic [3:0] ext_block;
    logic [4:0] p27_row;
  } spm_cap_req_t;

endpackage

// file: hw/spm_top.sv
`timescale 1ns/1ps
`include "spm_params.svh"
module spm_top
  import spm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire spm_cpu_req_t cpu_in,
  output logic cpu_ack,
  output logic [7:0] cpu_rdata,
  input wire logic disp_req,
  input wire logic [13:0] disp_addr,
  output logic disp_valid,
  output logic [7:0] disp_rdata,
  input wire logic line_start,
  input wire spm_cap_req_t cap_in,
  output logic clear_busy
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [9:0] disp_off(input logic [4:0] r, input logic [5:0] c);
    if (c < `SPM_COL_SPLIT) begin
      disp_off = {r, c[4:0]};
    end else begin
      disp_off = `SPM_HIGH_TOP - {2'b00, r, 3'b000} + {7'b0000000, c[2:0]};
    end
  endfunction

  function automatic logic [14:0] blk_phys(input logic [3:0] b, input logic [9:0] o);
    blk_phys = `SPM_DISP_BASE + {1'b0, b, o};
  endfunction

  // Control registers
  logic row24_placement_ff, inversion_enable_ff;
  logic [3:0] display_block_select_ff;
  logic [4:0] row_ptr_ff;
  logic [5:0] col_ptr_ff;
  logic clear_busy_ff;

  // AXI state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_ok_ff, w_ok_ff, wr_exec_ff;
  logic [5:0] aw_addr_ff, ar_addr_ff;
  logic [7:0] w_data_ff;
  logic w_lane0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic rpw_pend_ff, rpr_pend_ff;

  // Memory and arbitration
  logic [7:0] mem [0:`SPM_MEM_WORDS - 1];
  logic [15:0] ref_cnt_ff;
  logic cpu_ack_ff, disp_valid_ff;
  logic [7:0] cpu_rdata_ff, disp_rdata_ff;
  spm_gnt_t gnt;
  logic ref_slot, cpu_hit, mem_we;
  logic [14:0] mem_addr, cpu_phys, ptr_phys;
  logic [7:0] mem_wd, mem_q;

  // Clear engine
  spm_clr_state_t clr_state_ff;
  spm_job_t job_ff;
  logic [13:0] cnt_ff;
  logic [4:0] crow_ff, p27_ff;
  logic [5:0] ccol_ff;
  logic [3:0] cblk_ff, cext_ff;
  logic cx24_ff, cap_pend_ff, sw_pend_ff, line_used_ff;
  spm_cap_req_t cap_hold_ff;
  logic start_cap, start_sw, clr_last, clr_done, sw_req;
  logic [3:0] tgt_blk;
  logic [4:0] tgt_row;
  logic [14:0] clr_addr;
  logic [7:0] clr_fill;

  logic wr_go, ptr_row_wr, ptr_col_wr, rp_adv;

  assign wr_go = aw_ok_ff && w_ok_ff && !wr_exec_ff;
  assign ptr_row_wr = wr_go && w_lane0_ff && (aw_addr_ff == `SPM_OFF_ROW);
  assign ptr_col_wr = wr_go && w_lane0_ff && (aw_addr_ff == `SPM_OFF_COL);
  assign sw_req = ptr_row_wr && w_data_ff[`SPM_ROW_CLR_BIT];
  assign rp_adv = (gnt == SPM_GNT_REG);

  // AXI write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      wr_exec_ff <= 1'b0;
      aw_addr_ff <= 6'h00;
      w_data_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SPM_RESP_OKAY;
      rpw_pend_ff <= 1'b0;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_ok_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_ok_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        w_lane0_ff <= wstrb[0];
      end
      if (wr_go) begin
        wr_exec_ff <= 1'b1;
        // Data port writes wait for a DRAM slot before the response
        if (aw_addr_ff == `SPM_OFF_DATA && w_lane0_ff) begin
          rpw_pend_ff <= 1'b1;
        end else begin
          bvalid_ff <= 1'b1;
        end
        bresp_ff <= (aw_addr_ff > `SPM_OFF_STAT || aw_addr_ff[1:0] != 2'b00) ?
                    `SPM_RESP_SLVERR : `SPM_RESP_OKAY;
      end
      if (rp_adv && rpw_pend_ff) begin
        rpw_pend_ff <= 1'b0;
        bvalid_ff <= 1'b1;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        wr_exec_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {inversion_enable_ff, row24_placement_ff} <= `SPM_RST_CTRL;
      display_block_select_ff <= `SPM_RST_BLOCK;
    end else if (wr_go && w_lane0_ff) begin
      if (aw_addr_ff == `SPM_OFF_CTRL) begin
        row24_placement_ff <= w_data_ff[`SPM_CTRL_X24_BIT];
        inversion_enable_ff <= w_data_ff[`SPM_CTRL_INV_BIT];
      end
      if (aw_addr_ff == `SPM_OFF_BLOCK) begin
        display_block_select_ff <= w_data_ff[3:0];
      end
    end
  end

  // Row and column pointers; a software write beats the advance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_ptr_ff <= `SPM_RST_ROW;
      col_ptr_ff <= `SPM_RST_COL;
    end else begin
      if (ptr_row_wr) begin
        row_ptr_ff <= w_data_ff[4:0];
      end else if (rp_adv) begin
        if (row_ptr_ff == `SPM_ROW_LAST && col_ptr_ff == `SPM_COL_LAST) begin
          row_ptr_ff <= 5'h00;
        end else if (col_ptr_ff == `SPM_COL_MAX) begin
          row_ptr_ff <= row_ptr_ff + 5'h01;
        end
      end
      if (ptr_col_wr) begin
        col_ptr_ff <= w_data_ff[5:0];
      end else if (rp_adv) begin
        if ((row_ptr_ff == `SPM_ROW_LAST && col_ptr_ff == `SPM_COL_LAST) ||
            col_ptr_ff == `SPM_COL_MAX) begin
          col_ptr_ff <= 6'h00;
        end else begin
          col_ptr_ff <= col_ptr_ff + 6'h01;
        end
      end
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      ar_addr_ff <= 6'h00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SPM_RESP_OKAY;
      rpr_pend_ff <= 1'b0;
    end else begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        ar_addr_ff <= araddr;
        rresp_ff <= `SPM_RESP_OKAY;
        rdata_ff <= 32'h00000000;
        case (araddr)
          `SPM_OFF_CTRL: begin
            rdata_ff[1:0] <= {inversion_enable_ff, row24_placement_ff};
            rvalid_ff <= 1'b1;
          end
          `SPM_OFF_BLOCK: begin
            rdata_ff[3:0] <= display_block_select_ff;
            rvalid_ff <= 1'b1;
          end
          `SPM_OFF_ROW: begin
            rdata_ff[4:0] <= row_ptr_ff;
            rvalid_ff <= 1'b1;
          end
          `SPM_OFF_COL: begin
            rdata_ff[5:0] <= col_ptr_ff;
            rvalid_ff <= 1'b1;
          end
          `SPM_OFF_DATA: begin
            rpr_pend_ff <= 1'b1;
          end
          `SPM_OFF_STAT: begin
            rdata_ff[`SPM_STAT_BUSY_BIT] <= clear_busy_ff;
            rvalid_ff <= 1'b1;
          end
          default: begin
            rresp_ff <= `SPM_RESP_SLVERR;
            rvalid_ff <= 1'b1;
          end
        endcase
      end
      if (rp_adv && !rpw_pend_ff) begin
        rpr_pend_ff <= 1'b0;
        rdata_ff[7:0] <= mem_q;
        rvalid_ff <= 1'b1;
      end
      if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Processor address decode
  always_comb begin
    cpu_hit = (cpu_in.addr <= `SPM_TXT_HI) ||
              (cpu_in.addr >= `SPM_CC_LO && cpu_in.addr <= `SPM_CC_HI);
    if (cpu_in.addr[15]) begin
      cpu_phys = `SPM_DISP_BASE + cpu_in.addr[14:0];
    end else begin
      cpu_phys = cpu_in.addr[14:0];
    end
    ptr_phys = blk_phys(display_block_select_ff, disp_off(row_ptr_ff, col_ptr_ff));
  end

  // Refresh is deferred behind display so the raster never misses a fetch
  assign ref_slot = (ref_cnt_ff == 16'h0000) && !disp_req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_ff <= 16'((`SPM_REFRESH_CYC) - 1);
    end else if (ref_slot) begin
      ref_cnt_ff <= 16'((`SPM_REFRESH_CYC) - 1);
    end else if (ref_cnt_ff != 16'h0000) begin
      ref_cnt_ff <= ref_cnt_ff - 16'h0001;
    end
  end

  // Fixed priority arbiter
  always_comb begin
    gnt = SPM_GNT_NONE;
    if (disp_req) begin
      gnt = SPM_GNT_DISP;
    end else if (!ref_slot) begin
      if (clr_state_ff == SPM_CLR_RUN) begin
        gnt = SPM_GNT_CLR;
      end else if (cpu_in.req && cpu_hit && !cpu_ack_ff) begin
        gnt = SPM_GNT_CPU;
      end else if (rpw_pend_ff || rpr_pend_ff) begin
        gnt = SPM_GNT_REG;
      end
    end
  end

  always_comb begin
    mem_we = 1'b0;
    mem_addr = 15'h0000;
    mem_wd = 8'h00;
    case (gnt)
      SPM_GNT_DISP: mem_addr = `SPM_DISP_BASE + {1'b0, disp_addr};
      SPM_GNT_CLR: begin
        mem_we = 1'b1;
        mem_addr = clr_addr;
        mem_wd = clr_fill;
      end
      SPM_GNT_CPU: begin
        mem_we = cpu_in.we;
        mem_addr = cpu_phys;
        mem_wd = cpu_in.wdata;
      end
      SPM_GNT_REG: begin
        mem_we = rpw_pend_ff;
        mem_addr = ptr_phys;
        mem_wd = w_data_ff;
      end
      default: mem_we = 1'b0;
    endcase
    mem_q = (mem_addr < `SPM_MEM_WORDS) ? mem[mem_addr] : `SPM_UNMAPPED_DATA;
  end

  // No reset on the array: auxiliary contents survive reset untouched
  always_ff @(posedge aclk) begin
    if (mem_we && mem_addr < `SPM_MEM_WORDS) begin
      mem[mem_addr] <= mem_wd;
    end
  end

  // Requester answers; the processor stalls until cpu_ack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ack_ff <= 1'b0;
      cpu_rdata_ff <= 8'h00;
      disp_valid_ff <= 1'b0;
      disp_rdata_ff <= 8'h00;
    end else begin
      cpu_ack_ff <= (gnt == SPM_GNT_CPU) || (cpu_in.req && !cpu_hit && !cpu_ack_ff);
      if (gnt == SPM_GNT_CPU) begin
        cpu_rdata_ff <= mem_q;
      end else if (cpu_in.req && !cpu_hit) begin
        cpu_rdata_ff <= `SPM_UNMAPPED_DATA;
      end
      disp_valid_ff <= (gnt == SPM_GNT_DISP);
      if (gnt == SPM_GNT_DISP) begin
        disp_rdata_ff <= mem_q;
      end
    end
  end

  // Clear target for the current step
  always_comb begin
    tgt_blk = cblk_ff;
    tgt_row = crow_ff + 5'h01;
    if (crow_ff == `SPM_CAP_P27_IDX) begin
      tgt_blk = cext_ff;
      tgt_row = p27_ff;
    end else if (crow_ff == `SPM_CAP_LAST_IDX) begin
      tgt_blk = cx24_ff ? cblk_ff : cext_ff;
      tgt_row = cx24_ff ? `SPM_ROW24 : 5'h00;
    end
    case (job_ff)
      SPM_JOB_RST: begin
        clr_addr = `SPM_DISP_BASE + {1'b0, cnt_ff};
        clr_last = (cnt_ff == `SPM_DISP_LAST);
        clr_fill = `SPM_SPACE;
      end
      SPM_JOB_SW: begin
        clr_addr = blk_phys(cblk_ff, cnt_ff[9:0]);
        clr_last = (cnt_ff == `SPM_BLOCK_LAST);
        clr_fill = (inversion_enable_ff && cblk_ff == `SPM_INV_BLOCK) ?
                   `SPM_INV_FILL : `SPM_SPACE;
      end
      default: begin
        clr_addr = blk_phys(tgt_blk, disp_off(tgt_row, ccol_ff));
        clr_last = (crow_ff == `SPM_CAP_LAST_IDX) && (ccol_ff == `SPM_COL_MAX);
        clr_fill = (inversion_enable_ff && tgt_blk == `SPM_INV_BLOCK) ?
                   `SPM_INV_FILL : `SPM_SPACE;
      end
    endcase
  end

  assign start_cap = (clr_state_ff == SPM_CLR_IDLE) && cap_pend_ff;
  assign start_sw = (clr_state_ff == SPM_CLR_IDLE) && !cap_pend_ff && sw_pend_ff &&
                    !line_used_ff;
  assign clr_done = (gnt == SPM_GNT_CLR) && clr_last;

  // Clear engine; comes up running so every reset refills display RAM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_state_ff <= SPM_CLR_RUN;
      job_ff <= SPM_JOB_RST;
      cnt_ff <= 14'h0000;
      crow_ff <= 5'h00;
      ccol_ff <= 6'h00;
      cblk_ff <= 4'h0;
      cext_ff <= 4'h0;
      p27_ff <= 5'h00;
      cx24_ff <= 1'b0;
    end else begin
      case (clr_state_ff)
        SPM_CLR_IDLE: begin
          cnt_ff <= 14'h0000;
          crow_ff <= 5'h00;
          ccol_ff <= 6'h00;
          if (start_cap) begin
            clr_state_ff <= SPM_CLR_RUN;
            job_ff <= SPM_JOB_CAP;
            cblk_ff <= cap_hold_ff.block;
            cext_ff <= cap_hold_ff.ext_block;
            p27_ff <= cap_hold_ff.p27_row;
            cx24_ff <= row24_placement_ff;
          end else if (start_sw) begin
            clr_state_ff <= SPM_CLR_RUN;
            job_ff <= SPM_JOB_SW;
            cblk_ff <= display_block_select_ff;
          end
        end
        SPM_CLR_RUN: begin
          if (clr_done) begin
            clr_state_ff <= SPM_CLR_IDLE;
          end else if (gnt == SPM_GNT_CLR) begin
            cnt_ff <= cnt_ff + 14'h0001;
            if (ccol_ff == `SPM_COL_MAX) begin
              ccol_ff <= 6'h00;
              crow_ff <= crow_ff + 5'h01;
            end else begin
              ccol_ff <= ccol_ff + 6'h01;
            end
          end
        end
        default: clr_state_ff <= SPM_CLR_IDLE;
      endcase
    end
  end

  // Pending requests, line budget and busy flag; every set wins its clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_pend_ff <= 1'b0;
      cap_hold_ff <= '0;
      sw_pend_ff <= 1'b0;
      line_used_ff <= 1'b0;
      clear_busy_ff <= 1'b1;
    end else begin
      if (cap_in.clear) begin
        cap_pend_ff <= 1'b1;
        cap_hold_ff <= cap_in;
      end else if (start_cap) begin
        cap_pend_ff <= 1'b0;
      end
      if (sw_req) begin
        sw_pend_ff <= 1'b1;
      end else if (start_sw) begin
        sw_pend_ff <= 1'b0;
      end
      if (start_cap || start_sw) begin
        line_used_ff <= 1'b1;
      end else if (line_start) begin
        line_used_ff <= 1'b0;
      end
      if (sw_req) begin
        clear_busy_ff <= 1'b1;
      end else if (clr_done && job_ff != SPM_JOB_CAP && !sw_pend_ff) begin
        clear_busy_ff <= 1'b0;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign cpu_ack = cpu_ack_ff;
  assign cpu_rdata = cpu_rdata_ff;
  assign disp_valid = disp_valid_ff;
  assign disp_rdata = disp_rdata_ff;
  assign clear_busy = clear_busy_ff;

  sequence sw_req_s;
    sw_req && clr_state_ff == SPM_CLR_IDLE;
  endsequence
  sequence busy_hold_s;
    clear_busy_ff [*3];
  endsequence

  col_wrap_a: assert property ((rp_adv && col_ptr_ff == 6'h27 && row_ptr_ff < 5'h19 &&
      !ptr_row_wr && !ptr_col_wr) |=> (col_ptr_ff == 6'h00 &&
      row_ptr_ff == $past(row_ptr_ff) + 5'h01)) else $error("column did not wrap");
  page_wrap_a: assert property ((rp_adv && row_ptr_ff == 5'h19 && col_ptr_ff == 6'h17 &&
      !ptr_row_wr && !ptr_col_wr) |=> (row_ptr_ff == 5'h00 && col_ptr_ff == 6'h00))
    else $error("page end did not wrap");
  busy_set_a: assert property (sw_req_s |=> busy_hold_s) else $error("busy flag not held");
  reset_clear_a: assert property ($rose(aresetn) |->
      (clear_busy_ff && clr_state_ff == SPM_CLR_RUN && job_ff == SPM_JOB_RST))
    else $error("reset clear not started");
  inv_fill_a: assert property ((gnt == SPM_GNT_CLR && job_ff != SPM_JOB_RST &&
      inversion_enable_ff && clr_addr[14:10] == 5'h10) |-> mem_wd == 8'h00)
    else $error("inverted block not filled with zero");
  space_fill_a: assert property ((gnt == SPM_GNT_CLR && !inversion_enable_ff) |->
      (mem_we && mem_wd == 8'h20)) else $error("clear did not write space");
  aux_map_a: assert property ((gnt == SPM_GNT_CPU && cpu_in.addr < 16'h2000) |->
      mem_addr == cpu_in.addr[14:0]) else $error("auxiliary address mismatch");
  cc_map_a: assert property ((gnt == SPM_GNT_CPU && cpu_in.addr[15]) |->
      mem_addr == cpu_in.addr[14:0] + 15'h2000) else $error("caption alias mismatch");
  disp_first_a: assert property (disp_req |-> gnt == SPM_GNT_DISP ##1 disp_valid_ff)
    else $error("display not served first");
  line_once_a: assert property ((line_used_ff && !line_start) |=> !start_sw)
    else $error("second clear in one line");
  cap_order_a: assert property ((cap_in.clear && clr_state_ff == SPM_CLR_IDLE &&
      !start_cap && !start_sw) |=> start_cap) else $error("capture clear not started");

endmodule // spm_top

// file: verification/spm_far_model.sv
`timescale 1ns/1ps
module spm_far_model
  import spm_pkg::*;
#(
  parameter int LINE_CYC = 3000
) (
  input wire logic aclk,
  output spm_cpu_req_t cpu_in,
  input wire logic cpu_ack,
  input wire logic [7:0] cpu_rdata,
  output logic disp_req,
  output logic [13:0] disp_addr,
  input wire logic disp_valid,
  input wire logic [7:0] disp_rdata,
  output logic line_start,
  output spm_cap_req_t cap_in
);
  int cnt = 0;
  initial begin
    cpu_in = '0;
    disp_req = 1'b0;
    disp_addr = '0;
    cap_in = '0;
  end
  // Line timing runs free; it is the only source of a fresh clear budget
  always @(posedge aclk) begin
    cnt <= (cnt == LINE_CYC - 1) ? 0 : cnt + 1;
  end
  assign line_start = (cnt == LINE_CYC - 1);
  // Released payload is inverted so stale values never look valid
  task automatic cpu_acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge aclk);
    cpu_in <= '{1'b1, w, a, d};
    do @(posedge aclk); while (cpu_ack !== 1'b1);
    q = cpu_rdata;
    cpu_in <= '{1'b0, ~w, ~a, ~d};
  endtask
  task automatic disp_rd(input logic [13:0] a, output logic [7:0] q);
    disp_req <= 1'b1;
    disp_addr <= a;
    @(posedge aclk);
    disp_req <= 1'b0;
    disp_addr <= ~a;
    do @(posedge aclk); while (disp_valid !== 1'b1);
    q = disp_rdata;
  endtask
  task automatic cap_clear(input logic [3:0] b, input logic [3:0] e, input logic [4:0] r);
    cap_in <= '{1'b1, b, e, r};
    @(posedge aclk);
    cap_in <= '{1'b0, ~b, ~e, ~r};
  endtask
endmodule // spm_far_model

// file: verification/spm_top_tb_top.sv
`timescale 1ns/1ps
`include "spm_params.svh"
module spm_top_tb_top
  import spm_pkg::*;
;
  localparam int LINE = 3000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, cpu_ack, disp_req, disp_valid, line_start, clear_busy;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, rb;
  logic [7:0] cpu_rdata, disp_rdata;
  logic [13:0] disp_addr;
  spm_cpu_req_t cpu_in;
  spm_cap_req_t cap_in;
  int err_total, n_checks, cyc;
  spm_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .cpu_in, .cpu_ack, .cpu_rdata, .disp_req, .disp_addr,
    .disp_valid, .disp_rdata, .line_start, .cap_in, .clear_busy);
  spm_far_model #(.LINE_CYC(LINE)) p (.aclk, .cpu_in, .cpu_ack, .cpu_rdata, .disp_req,
    .disp_addr, .disp_valid, .disp_rdata, .line_start, .cap_in);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    rb = bresp;
  endtask
  task automatic reg_chk(input logic [5:0] a, input logic [7:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rr = rresp;
    chk("register", rdata, {24'h0, e});
  endtask
  task automatic mem_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    p.cpu_acc(1'b0, a, 8'h00, q);
    chk("memory", {24'h0, q}, {24'h0, e});
  endtask
  task automatic t_reset();
    logic [7:0] q;
    chk("busy", {31'h0, clear_busy}, 32'h1);
    while (clear_busy !== 1'b0) @(posedge aclk);
    reg_chk(`SPM_OFF_STAT, 8'h00);
    p.disp_rd(14'h27ff, q);
    chk("display", {24'h0, q}, 32'h20);
    mem_chk(16'h2000, 8'h20);
  endtask
  task automatic t_ptr();
    logic [7:0] q;
    wr(`SPM_OFF_BLOCK, 8'h02);
    chk("bresp", {30'h0, rb}, {30'h0, `SPM_RESP_OKAY});
    wr(6'h18, 8'h00);
    chk("bresp", {30'h0, rb}, {30'h0, `SPM_RESP_SLVERR});
    wr(`SPM_OFF_ROW, 8'h00);
    wr(`SPM_OFF_COL, 8'h27);
    wr(`SPM_OFF_DATA, 8'h41);
    reg_chk(`SPM_OFF_ROW, 8'h01);
    reg_chk(`SPM_OFF_COL, 8'h00);
    mem_chk(16'h2bff, 8'h41);
    wr(`SPM_OFF_ROW, 8'h19);
    wr(`SPM_OFF_COL, 8'h17);
    wr(`SPM_OFF_DATA, 8'h42);
    reg_chk(`SPM_OFF_ROW, 8'h00);
    reg_chk(`SPM_OFF_COL, 8'h00);
    mem_chk(16'h2b37, 8'h42);
    p.cpu_acc(1'b1, 16'h26ff, 8'h44, q);
    mem_chk(16'h86ff, 8'h44);
    mem_chk(16'h8b37, 8'hff);
    p.cpu_acc(1'b1, 16'h2b38, 8'h43, q);
    wr(`SPM_OFF_ROW, 8'h18);
    wr(`SPM_OFF_COL, 8'h20);
    reg_chk(`SPM_OFF_DATA, 8'h43);
    reg_chk(`SPM_OFF_COL, 8'h21);
    p.cpu_acc(1'b1, 16'h1fff, 8'h5a, q);
    mem_chk(16'h1fff, 8'h5a);
    reg_chk(6'h18, 8'h00);
    chk("rresp", {30'h0, rr}, {30'h0, `SPM_RESP_SLVERR});
  endtask
  task automatic t_clr(input logic [7:0] b, input logic [7:0] c, input logic [15:0] a,
                       input logic [7:0] e);
    wr(`SPM_OFF_CTRL, c);
    wr(`SPM_OFF_BLOCK, b);
    wr(`SPM_OFF_ROW, 8'h80);
    chk("busy", {31'h0, clear_busy}, 32'h1);
    reg_chk(`SPM_OFF_ROW, 8'h00);
    while (clear_busy !== 1'b0) @(posedge aclk);
    mem_chk(a, e);
  endtask
  task automatic t_cap(input logic [7:0] c, input logic [7:0] e24, input logic [7:0] e0);
    logic [7:0] q;
    logic [15:0] ad[5] = '{16'h2400, 16'h2425, 16'h2700, 16'h2ee0, 16'h2c00};
    logic [7:0] ex[5] = '{8'h55, 8'h20, 8'h20, 8'h20, 8'h55};
    ex[2] = e24;
    ex[4] = e0;
    wr(`SPM_OFF_CTRL, c);
    foreach (ad[i]) p.cpu_acc(1'b1, ad[i], 8'h55, q);
    @(posedge line_start);
    p.cap_clear(4'h1, 4'h3, 5'h17);
    // Checked just before the next line starts: the clear must fit its own line
    repeat (LINE - 4) @(posedge aclk);
    foreach (ad[i]) mem_chk(ad[i], ex[i]);
  endtask
  // Mid-run reset: display refilled, auxiliary words untouched
  task automatic t_rst2();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    mem_chk(16'h43ff, 8'h20);
    mem_chk(16'h1fff, 8'h5a);
  endtask
  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h1;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ptr();
    t_clr(8'h02, 8'h00, 16'h2bff, 8'h20);
    t_clr(8'h08, 8'h02, 16'h43ff, 8'h00);
    t_cap(8'h01, 8'h20, 8'h55);
    t_cap(8'h00, 8'h55, 8'h20);
    t_rst2();
    finish_test();
  end
endmodule // spm_top_tb_top
